// ### tx_frame_timing_defines.svh
// constants for the transmit framing and timing block
`ifndef TX_FRAME_TIMING_DEFINES_SVH
`define TX_FRAME_TIMING_DEFINES_SVH

// ==========================================================================
// register indices (byte address = index * 4)
`define IDX_BURST 10'h030
`define IDX_WAIT_CTRL 10'h031
`define IDX_WAIT_LOW 10'h032
`define IDX_FRAME 10'h033
`define IDX_CONTROL 10'h038
`define IDX_STATUS 10'h039
`define IDX_RX_DATA 10'h03A

// ==========================================================================
// reset values and writable masks
`define BURST_RST 8'h00
`define WAIT_CTRL_RST 8'hC0
`define WAIT_LOW_RST 8'h00
`define FRAME_RST 8'h00
`define CONTROL_RST 8'h00
`define BURST_MASK 8'h77
`define FRAME_MASK 8'hCF
`define CONTROL_MASK 8'h0F

// ==========================================================================
// field positions
`define SYM_ONE_LSB 4
`define SYM_ZERO_LSB 0
`define WAIT_START_BIT 7
`define WAIT_UNIT_BIT 6
`define WAIT_HI_LSB 3
`define STOP_LEN_LSB 0
`define TX_PAR_BIT 7
`define RX_PAR_BIT 6
`define STOP_SYM_LSB 2
`define START_SYM_LSB 0
`define TYPE_B_BIT 0
`define BURST_LEVEL_BIT 1
`define RATE_LSB 2
`define ST_BUSY_BIT 0
`define ST_WAIT_BIT 1
`define ST_PAR_ERR_BIT 2
`define ST_OVF_BIT 3
`define ST_LEVEL_LSB 8

// ==========================================================================
// timing
`define CLK_KHZ 100000
`define CARRIER_KHZ 13560
`define WAIT_CARRIERS 16
`define WAIT_UNIT_CYC ((`WAIT_CARRIERS * `CLK_KHZ + `CARRIER_KHZ - 1) / `CARRIER_KHZ)
`define BASE_RATE_KHZ 106
`define BYTE_BITS_M1 9'h007

`endif

// ### tx_frame_timing_pkg.sv
// types shared by the transmit framing and timing block
`default_nettype none
package tx_frame_timing_pkg;
    // ======================================================================
    // transmit sequencer states
    typedef enum logic [3:0] {
        S_IDLE, S_START, S_LOAD, S_DATA, S_PARITY, S_STOP, S_EGT, S_END
    } tx_state_t;
    // ======================================================================
    // kind of element on the transmit bit stream
    typedef enum logic [1:0] {
        K_DATA, K_SYM0, K_SYM1, K_SYM2
    } tx_kind_t;
endpackage
`default_nettype wire

// ### stream_fifo.sv
// flip-flop fifo with valid/ready on both sides
`default_nettype none
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    // ======================================================================
    // storage and pointers
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic full_reg;
    logic empty_reg;
    wire push = ce && in_valid && !full_reg;
    wire pop = ce && out_ready && !empty_reg;
    wire [AW:0] count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

    assign in_ready = !full_reg;
    assign out_valid = !empty_reg;
    assign out_data = mem_reg[rd_ptr_reg];
    assign level = count_reg;

    always_ff @(posedge pclk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // flags are registered so the top sees them straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            full_reg <= 1'b0;
            empty_reg <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
            full_reg <= (count_next == (AW+1)'(DEPTH));
            empty_reg <= (count_next == '0);
        end
    end
endmodule
`default_nettype wire

// ### tx_frame_timing_config.sv
// transmit framing, guard wait and parity block with apb registers
//
// Decided for this implementation: the APB register port.
`include "tx_frame_timing_defines.svh"
`default_nettype none
module tx_frame_timing_config
    import tx_frame_timing_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata_reg,
    output logic pready_reg,
    output logic pslverr_reg,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready_reg,
    output logic tx_bit_reg,
    output logic tx_strobe_reg,
    output logic [1:0] tx_kind_reg,
    output logic tx_active_reg,
    input wire logic rx_bit,
    input wire logic rx_bit_valid,
    input wire logic rx_end,
    output logic rx_ready
);
    // ======================================================================
    // helpers
    function automatic logic [8:0] burst_bits(input logic [2:0] code);
        logic [8:0] n;
        unique case (code)
            3'h0: n = 9'h008;
            3'h1: n = 9'h010;
            3'h2: n = 9'h020;
            3'h3: n = 9'h030;
            3'h4: n = 9'h040;
            3'h5: n = 9'h060;
            3'h6: n = 9'h080;
            3'h7: n = 9'h100;
        endcase
        return n;
    endfunction

    function automatic logic [9:0] half_bit_cyc(input logic [1:0] code);
        int r;
        r = `BASE_RATE_KHZ << code;
        return 10'((`CLK_KHZ + 2 * r - 1) / (2 * r));
    endfunction

    // ======================================================================
    // registers
    logic [7:0] burst_reg;
    logic [7:0] wait_ctrl_reg;
    logic [7:0] wait_low_reg;
    logic [7:0] frame_reg;
    logic [7:0] control_reg;
    logic par_err_reg;
    logic ovf_reg;

    wire [2:0] symbol_one_burst_length = burst_reg[`SYM_ONE_LSB +: 3];
    wire [2:0] symbol_zero_burst_length = burst_reg[`SYM_ZERO_LSB +: 3];
    wire wait_start_select = wait_ctrl_reg[`WAIT_START_BIT];
    wire wait_unit_select = wait_ctrl_reg[`WAIT_UNIT_BIT];
    wire [2:0] wait_upper_bits = wait_ctrl_reg[`WAIT_HI_LSB +: 3];
    wire [2:0] stop_length_field = wait_ctrl_reg[`STOP_LEN_LSB +: 3];
    wire [10:0] guard_wait_value = {wait_upper_bits, wait_low_reg};
    wire transmit_parity_enable = frame_reg[`TX_PAR_BIT];
    wire receive_parity_enable = frame_reg[`RX_PAR_BIT];
    wire [1:0] stop_symbol_select = frame_reg[`STOP_SYM_LSB +: 2];
    wire [1:0] start_symbol_select = frame_reg[`START_SYM_LSB +: 2];
    wire type_b_mode = control_reg[`TYPE_B_BIT];
    wire burst_level_control = control_reg[`BURST_LEVEL_BIT];
    wire [1:0] transmit_bit_rate = control_reg[`RATE_LSB +: 2];

    // ======================================================================
    // apb decode
    wire [ADDR_W-3:0] idx = paddr[ADDR_W-1:2];
    wire setup = psel && !penable;
    wire acc_done = psel && penable && pready_reg;
    wire wr_en = acc_done && pwrite && pstrb[0];
    wire hit_burst = (idx == `IDX_BURST);
    wire hit_wait_ctrl = (idx == `IDX_WAIT_CTRL);
    wire hit_wait_low = (idx == `IDX_WAIT_LOW);
    wire hit_frame = (idx == `IDX_FRAME);
    wire hit_control = (idx == `IDX_CONTROL);
    wire hit_status = (idx == `IDX_STATUS);
    wire hit_rx_data = (idx == `IDX_RX_DATA);
    wire hit = hit_burst || hit_wait_ctrl || hit_wait_low || hit_frame
        || hit_control || hit_status || hit_rx_data;

    // ======================================================================
    // receive fifo
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic [$clog2(FIFO_DEPTH):0] fifo_level;
    logic [7:0] fifo_in_data;
    logic rx_push;
    wire fifo_pop = acc_done && !pwrite && hit_rx_data && fifo_out_valid;

    stream_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) rx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .in_valid(rx_push),
        .in_ready(rx_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    // ======================================================================
    // transmit sequencer signals
    tx_state_t state_reg;
    tx_state_t state_next;
    logic [8:0] sym_left_reg;
    logic [8:0] len_next;
    logic [1:0] sym_code_reg;
    logic [1:0] code_next;
    logic [10:0] bit_timer_reg;
    logic [7:0] byte_reg;
    logic last_reg;
    logic done_evt;
    logic [10:0] wait_cnt_reg;
    logic [9:0] unit_cnt_reg;

    wire wait_done = (wait_cnt_reg == 11'h000);
    wire busy = (state_reg != S_IDLE);

    // ======================================================================
    // status and read mux
    wire [31:0] status_word = {19'h00000, 5'(fifo_level), 4'h0, ovf_reg, par_err_reg,
        !wait_done, busy};
    wire [7:0] rd_byte = hit_burst ? burst_reg
        : hit_wait_ctrl ? wait_ctrl_reg
        : hit_wait_low ? wait_low_reg
        : hit_frame ? frame_reg
        : hit_control ? control_reg
        : hit_rx_data ? (fifo_out_valid ? fifo_out_data : 8'h00)
        : 8'h00;
    wire [31:0] rd_word = hit_status ? status_word : {24'h000000, rd_byte};

    // answer in the first access cycle; reads sample at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else if (ce) begin
            pready_reg <= setup;
            pslverr_reg <= setup && !hit;
            prdata_reg <= (setup && !pwrite) ? rd_word : prdata_reg;
        end
    end

    // reserved positions are masked off on write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_reg <= `BURST_RST;
            wait_ctrl_reg <= `WAIT_CTRL_RST;
            wait_low_reg <= `WAIT_LOW_RST;
            frame_reg <= `FRAME_RST;
            control_reg <= `CONTROL_RST;
        end else if (ce && wr_en) begin
            if (hit_burst) burst_reg <= pwdata[7:0] & `BURST_MASK;
            if (hit_wait_ctrl) wait_ctrl_reg <= pwdata[7:0];
            if (hit_wait_low) wait_low_reg <= pwdata[7:0];
            if (hit_frame) frame_reg <= pwdata[7:0] & `FRAME_MASK;
            if (hit_control) control_reg <= pwdata[7:0] & `CONTROL_MASK;
        end
    end

    // ======================================================================
    // guard wait timer
    wire [9:0] unit_len = wait_unit_select ? half_bit_cyc(transmit_bit_rate)
        : 10'(`WAIT_UNIT_CYC);
    wire wait_trig = (done_evt && !wait_start_select) || (rx_end && wait_start_select);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt_reg <= 11'h000;
            unit_cnt_reg <= 10'h000;
        end else if (ce) begin
            if (wait_trig) begin
                wait_cnt_reg <= guard_wait_value;
                unit_cnt_reg <= unit_len - 10'h001;
            end else if (!wait_done) begin
                unit_cnt_reg <= (unit_cnt_reg == 10'h000) ? unit_len - 10'h001
                    : unit_cnt_reg - 10'h001;
                if (unit_cnt_reg == 10'h000) wait_cnt_reg <= wait_cnt_reg - 11'h001;
            end
        end
    end

    // ======================================================================
    // transmit sequencer
    wire timed = busy && (state_reg != S_LOAD);
    wire [10:0] bit_period = {half_bit_cyc(transmit_bit_rate), 1'b0};
    wire bit_tick = timed && (bit_timer_reg == 11'h000);
    wire adv = bit_tick && (sym_left_reg == 9'h000);
    // symbol 2 is a single bit; symbols 0 and 1 are programmed bursts
    wire [8:0] start_len = (start_symbol_select == 2'h1) ? burst_bits(symbol_zero_burst_length)
        : (start_symbol_select == 2'h2) ? burst_bits(symbol_one_burst_length) : 9'h001;
    wire [8:0] stop_len = (stop_symbol_select == 2'h1) ? burst_bits(symbol_zero_burst_length)
        : (stop_symbol_select == 2'h2) ? burst_bits(symbol_one_burst_length) : 9'h001;
    wire go = tx_valid && wait_done && !wait_trig;

    always_comb begin
        logic char_end;
        logic after;
        char_end = 1'b0;
        after = 1'b0;
        state_next = state_reg;
        len_next = (bit_tick && sym_left_reg != 9'h000) ? sym_left_reg - 9'h001 : sym_left_reg;
        code_next = sym_code_reg;
        done_evt = 1'b0;
        unique case (state_reg)
            S_IDLE: begin
                if (go && start_symbol_select != 2'h0) begin
                    state_next = S_START;
                    code_next = start_symbol_select;
                    len_next = start_len - 9'h001;
                end else if (go) begin
                    state_next = S_LOAD;
                end
            end
            S_START: begin
                if (adv) state_next = S_LOAD;
            end
            S_LOAD: begin
                if (tx_valid && tx_ready_reg) begin
                    state_next = S_DATA;
                    len_next = `BYTE_BITS_M1;
                end
            end
            S_DATA: begin
                if (adv && transmit_parity_enable) begin
                    state_next = S_PARITY;
                    len_next = 9'h000;
                end else if (adv) begin
                    char_end = 1'b1;
                end
            end
            S_PARITY: begin
                if (adv) char_end = 1'b1;
            end
            S_STOP: begin
                if (adv && stop_length_field > 3'h1) begin
                    state_next = S_EGT;
                    len_next = 9'(stop_length_field - 3'h2);
                end else if (adv) begin
                    after = 1'b1;
                end
            end
            S_EGT: begin
                if (adv) after = 1'b1;
            end
            S_END: begin
                if (adv) begin
                    state_next = S_IDLE;
                    done_evt = 1'b1;
                end
            end
        endcase
        if (char_end && type_b_mode && stop_length_field != 3'h0) begin
            state_next = S_STOP;
            len_next = 9'h000;
        end else if (char_end) begin
            after = 1'b1;
        end
        if (after && !last_reg) begin
            state_next = S_LOAD;
        end else if (after && stop_symbol_select != 2'h0) begin
            state_next = S_END;
            code_next = stop_symbol_select;
            len_next = stop_len - 9'h001;
        end else if (after) begin
            state_next = S_IDLE;
            done_evt = 1'b1;
        end
    end

    // bit value of the element being sent
    wire sym_bit = (sym_code_reg == 2'h3) ? !burst_level_control : burst_level_control;
    wire data_bit = byte_reg[3'(4'h7 - 4'(sym_left_reg[2:0]))];
    wire parity_bit = ~^byte_reg;
    wire bit_now = (state_reg == S_DATA) ? data_bit
        : (state_reg == S_PARITY) ? parity_bit
        : (state_reg == S_START || state_reg == S_END) ? sym_bit
        : 1'b1;
    wire in_sym = (state_reg == S_START) || (state_reg == S_END);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            sym_left_reg <= 9'h000;
            sym_code_reg <= 2'h0;
            bit_timer_reg <= 11'h000;
        end else if (ce) begin
            state_reg <= state_next;
            sym_left_reg <= len_next;
            sym_code_reg <= code_next;
            bit_timer_reg <= (timed && !bit_tick) ? bit_timer_reg - 11'h001
                : bit_period - 11'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_reg <= 8'h00;
            last_reg <= 1'b0;
            tx_ready_reg <= 1'b0;
            tx_bit_reg <= 1'b1;
            tx_strobe_reg <= 1'b0;
            tx_kind_reg <= 2'h0;
            tx_active_reg <= 1'b0;
        end else if (ce) begin
            if (tx_valid && tx_ready_reg) begin
                byte_reg <= tx_data;
                last_reg <= tx_last;
            end
            tx_ready_reg <= (state_next == S_LOAD);
            tx_bit_reg <= bit_now;
            tx_strobe_reg <= bit_tick;
            tx_kind_reg <= in_sym ? sym_code_reg : 2'h0;
            tx_active_reg <= timed;
        end
    end

    // ======================================================================
    // receive deframer
    logic [3:0] rx_cnt_reg;
    logic [8:0] rx_shift_reg;
    wire [3:0] rx_need = receive_parity_enable ? 4'h8 : 4'h7;
    wire rx_last = rx_bit_valid && (rx_cnt_reg == rx_need);
    wire rx_par_bad = receive_parity_enable && rx_last && (rx_bit == ^rx_shift_reg[7:0]);
    // parity never reaches the fifo, only the eight data bits
    assign fifo_in_data = receive_parity_enable ? rx_shift_reg[7:0]
        : {rx_bit, rx_shift_reg[6:0]};
    assign rx_push = rx_last;
    wire sts_clear = wr_en && hit_status;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt_reg <= 4'h0;
            rx_shift_reg <= 9'h000;
            par_err_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else if (ce) begin
            if (rx_end || rx_last) rx_cnt_reg <= 4'h0;
            else if (rx_bit_valid) rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_bit_valid) rx_shift_reg[rx_cnt_reg] <= rx_bit;
            // a new event beats a clear in the same cycle
            par_err_reg <= rx_par_bad || (par_err_reg
                && !(sts_clear && pwdata[`ST_PAR_ERR_BIT]));
            ovf_reg <= (rx_push && !rx_ready) || (ovf_reg && !(sts_clear && pwdata[`ST_OVF_BIT]));
        end
    end

    // ======================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_idle_blocked;
        ce && state_reg == S_IDLE && (!wait_done || wait_trig);
    endsequence
    sequence s_tx_done_trig;
        ce && done_evt && !wait_start_select;
    endsequence

    property p_no_early_start;
        s_idle_blocked |=> state_reg == S_IDLE;
    endproperty
    a_no_early_start: assert property (p_no_early_start) else $error("tx left idle in wait");

    property p_tx_wait_load;
        s_tx_done_trig |=> wait_cnt_reg == $past(guard_wait_value);
    endproperty
    a_tx_wait_load: assert property (p_tx_wait_load) else $error("wait not loaded at tx end");

    property p_rx_wait_load;
        ce && rx_end && wait_start_select |=> wait_cnt_reg == $past(guard_wait_value);
    endproperty
    a_rx_wait_load: assert property (p_rx_wait_load) else $error("wait not loaded at rx end");

    property p_unit_hold;
        ce && !wait_trig && !wait_done && unit_cnt_reg != 10'h000 |=> $stable(wait_cnt_reg);
    endproperty
    a_unit_hold: assert property (p_unit_hold) else $error("wait count stepped early");

    property p_parity_bit;
        ce && state_reg == S_PARITY ##1 ce |-> tx_bit_reg == ~^byte_reg;
    endproperty
    a_parity_bit: assert property (p_parity_bit) else $error("parity bit not odd");

    property p_stop_type_b;
        state_reg == S_STOP || state_reg == S_EGT |-> type_b_mode;
    endproperty
    a_stop_type_b: assert property (p_stop_type_b) else $error("stop bits outside type b");

    property p_rx_push;
        rx_push |-> rx_bit_valid && rx_cnt_reg == (receive_parity_enable ? 4'h8 : 4'h7);
    endproperty
    a_rx_push: assert property (p_rx_push) else $error("rx byte pushed at wrong bit");

    property p_reserved_zero;
        burst_reg[7] == 1'b0 && burst_reg[3] == 1'b0 && frame_reg[5:4] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_start_burst;
        ce && state_reg == S_IDLE && state_next == S_START
            |=> sym_left_reg == $past(start_len) - 9'h001;
    endproperty
    a_start_burst: assert property (p_start_burst) else $error("burst length wrong");
endmodule
`default_nettype wire

// ### placeholder_none.sv
// intentionally unused
`default_nettype none
`default_nettype wire

// ### rf_card_model.sv
// far-side card model: captures transmitted bits, sends received bytes
`default_nettype none
module rf_card_model (
    input wire logic pclk,
    input wire logic tx_strobe,
    input wire logic tx_bit,
    output logic rx_bit,
    output logic rx_bit_valid,
    output logic rx_end
);
    timeunit 1ns;
    timeprecision 1ns;
    int strobes = 0;
    logic [8:0] seen = '0;
    initial begin
        rx_bit = 1'b1;
        rx_bit_valid = 1'b0;
        rx_end = 1'b0;
    end
    always @(posedge pclk) begin
        if (tx_strobe === 1'b1) begin
            strobes++;
            seen <= {tx_bit, seen[8:1]};
        end
    end
    // nine bits lsb first, then end of reception
    task automatic send(input logic [8:0] bits);
        for (int i = 0; i < 9; i++) begin
            rx_bit <= bits[i];
            rx_bit_valid <= 1'b1;
            @(posedge pclk);
            rx_bit_valid <= 1'b0;
            // line shows no stale bit between strobes
            rx_bit <= ~bits[i];
            repeat (2) @(posedge pclk);
        end
        rx_end <= 1'b1;
        @(posedge pclk);
        rx_end <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the transmit framing and timing block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tx_valid = 0, tx_last = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata_reg, rd, v;
    logic pready_reg, pslverr_reg, err, tx_ready_reg, tx_bit_reg, tx_strobe_reg, tx_active_reg;
    logic rx_bit, rx_bit_valid, rx_end, rx_ready;
    logic [7:0] tx_data = '0, b;
    logic [1:0] tx_kind_reg;
    logic [7:0] q[$];
    int fails = 0, checks_done = 0, seed = 25695;
    always #5 pclk = ~pclk;
    tx_frame_timing_config i_tx_frame_timing_config (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata_reg(prdata_reg), .pready_reg(pready_reg),
        .pslverr_reg(pslverr_reg), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .tx_ready_reg(tx_ready_reg), .tx_bit_reg(tx_bit_reg), .tx_strobe_reg(tx_strobe_reg),
        .tx_kind_reg(tx_kind_reg), .tx_active_reg(tx_active_reg), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid), .rx_end(rx_end), .rx_ready(rx_ready));
    rf_card_model i_rf_card_model (.pclk(pclk), .tx_strobe(tx_strobe_reg), .tx_bit(tx_bit_reg),
        .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_end(rx_end));
    // ======================================================================
    // helpers
    function automatic logic [7:0] mask(input int i);
        return (i == 0) ? 8'h77 : (i == 3) ? 8'hCF : 8'hFF;
    endfunction
    function automatic logic par(input logic [7:0] d);
        return ~^d;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready_reg !== 1'b1);
        rd = prdata_reg;
        err = pslverr_reg;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic end_sim;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ======================================================================
    // sequence
    initial begin
        repeat (30000) @(posedge pclk);
        fails++;
        end_sim;
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 12'h0C4, 0);
        check(rd, 32'hC0);
        for (int n = 0; n < 6; n++) begin
            for (int i = 0; i < 4; i++) begin
                v = $random(seed);
                apb(1, 12'h0C0 + 12'(i * 4), v);
                apb(0, 12'h0C0 + 12'(i * 4), 0);
                check(rd, {24'h0, v[7:0] & mask(i)});
            end
        end
        apb(0, 12'h0FC, 0);
        check({31'h0, err}, 1);
        // 848 kbit/s keeps a bit at 118 cycles, type a, parity on, stop length ignored
        apb(1, 12'h0E0, 32'h0C);
        apb(1, 12'h0C4, 32'h03);
        apb(1, 12'h0C8, 0);
        apb(1, 12'h0CC, 32'h80);
        tx_data <= 8'hA5;
        tx_valid <= 1'b1;
        tx_last <= 1'b1;
        do @(posedge pclk); while (tx_ready_reg !== 1'b1);
        tx_valid <= 1'b0;
        while (i_rf_card_model.strobes < 9) @(posedge pclk);
        repeat (400) @(posedge pclk);
        check(i_rf_card_model.strobes, 9);
        check({23'h0, i_rf_card_model.seen}, {23'h0, par(8'hA5), 8'hA5});
        apb(1, 12'h0CC, 32'h40);
        // guard wait of 2 carrier units, started by the end of reception
        apb(1, 12'h0C4, 32'h80);
        apb(1, 12'h0C8, 32'h02);
        for (int k = 0; k < 17; k++) begin
            b = 8'($random(seed));
            if (k < 16) q.push_back(b);
            i_rf_card_model.send({par(b), b});
        end
        check({31'h0, rx_ready}, 0);
        apb(0, 12'h0E4, 0);
        check({27'h0, rd[12:8]}, 16);
        check({31'h0, rd[3]}, 1);
        check({31'h0, rd[1]}, 32'h1);
        for (int k = 0; k < 16; k++) begin
            apb(0, 12'h0E8, 0);
            check(rd, {24'h0, q.pop_front()});
        end
        check({31'h0, rx_ready}, 1);
        repeat (140) @(posedge pclk);
        apb(0, 12'h0E4, 0);
        check({31'h0, rd[1]}, 32'h1);
        repeat (50) @(posedge pclk);
        apb(0, 12'h0E4, 0);
        check({31'h0, rd[1]}, 32'h0);
        // type b: sym1 start 16, byte, parity, stop + 2 guard, sym0 end 8
        apb(1, 12'h0E0, 32'h0D);
        apb(1, 12'h0C0, 32'h10);
        apb(1, 12'h0C4, 32'h43);
        apb(1, 12'h0C8, 32'h04);
        apb(1, 12'h0CC, 32'h86);
        tx_valid <= 1'b1;
        do @(posedge pclk); while (tx_ready_reg !== 1'b1);
        tx_valid <= 1'b0;
        while (i_rf_card_model.strobes < 45) @(posedge pclk);
        apb(0, 12'h0E4, 0);
        check({31'h0, rd[1]}, 32'h1);
        check({23'h0, i_rf_card_model.seen}, 32'h001);
        // half-bit units: 4 x 59 cycles of guard wait before the next frame
        tx_valid <= 1'b1;
        repeat (150) @(posedge pclk);
        check({31'h0, tx_active_reg}, 32'h0);
        check(i_rf_card_model.strobes, 45);
        repeat (100) @(posedge pclk);
        check({31'h0, tx_active_reg}, 32'h1);
        do @(posedge pclk); while (tx_ready_reg !== 1'b1);
        tx_valid <= 1'b0;
        while (i_rf_card_model.strobes < 81) @(posedge pclk);
        repeat (10) @(posedge pclk);
        check(i_rf_card_model.strobes, 81);
        end_sim;
    end
endmodule
`default_nettype wire
